// [common/spio_map.svh]
// Register offsets, field positions and reset values of the shared pin port.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef SPIO_MAP_SVH
`define SPIO_MAP_SVH

`define SPIO_OFF_DATA   8'h00
`define SPIO_OFF_DIR    8'h04
`define SPIO_OFF_PU     8'h08
`define SPIO_OFF_OD     8'h0C
`define SPIO_OFF_PD     8'h10
`define SPIO_OFF_ANA    8'h14
`define SPIO_OFF_KEY    8'h18
`define SPIO_OFF_FUNC   8'h1C
`define SPIO_OFF_PIN    8'h20
`define SPIO_OFF_ISTS   8'h24
`define SPIO_OFF_IMASK  8'h28

`define SPIO_FN_TMA     0
`define SPIO_FN_TMB     1
`define SPIO_FN_WPWM    2
`define SPIO_FN_WPSEL   3
`define SPIO_FN_NPWM    4
`define SPIO_FN_XRST    5
`define SPIO_FN_E0_LO   6
`define SPIO_FN_E1_LO   8
`define SPIO_FN_EK_LO   10
`define SPIO_FN_I0SEL   12

`define SPIO_IRQ_E0     0
`define SPIO_IRQ_E1     1
`define SPIO_IRQ_KEY    2

`define SPIO_PIN_A0     0
`define SPIO_PIN_A1     1
`define SPIO_PIN_A2     2
`define SPIO_PIN_B1     3
`define SPIO_PIN_B2     4
`define SPIO_PIN_B3     5

`define SPIO_ANA_MASK   6'h37
`define SPIO_PD_MASK    6'h30
`define SPIO_OD_FORCE   6'h08
`define SPIO_RST_PINCFG 6'h00
`define SPIO_RST_FUNC   13'h0000
`define SPIO_RST_IRQ    3'h0

`endif

// [common/spio_pkg.sv]
// Types of the shared pin port: edge modes, APB carrier and the state record.
// Assumes spio_map.svh for widths of the function word.
package spio_pkg;

	// Edge selection for external and key-scan interrupts
	typedef enum logic [1:0] {
		SPIO_EDGE_OFF  = 2'h0,
		SPIO_EDGE_RISE = 2'h1,
		SPIO_EDGE_FALL = 2'h2,
		SPIO_EDGE_BOTH = 2'h3
	} spio_edge_t;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} spio_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} spio_apb_rsp_t;

	// Complete state of the port block
	typedef struct packed {
		logic [5:0]    data;
		logic [5:0]    dir;
		logic [5:0]    pu;
		logic [5:0]    od;
		logic [5:0]    pd;
		logic [5:0]    ana;
		logic [5:0]    key_en;
		logic [12:0]   func;
		logic [2:0]    ists;
		logic [2:0]    imask;
		logic [5:0]    sync1;
		logic [5:0]    sync2;
		logic [5:0]    prev;
		logic [5:0]    pout;
		logic [5:0]    poe;
		logic [5:0]    ppu;
		logic [5:0]    ppd;
		logic [5:0]    pana;
		logic          irq;
		logic          wake;
		logic          xrst_n;
		logic [1:0]    cap;
		logic [1:0]    evt;
		logic          sck;
		logic          sda_in;
		spio_apb_rsp_t apb;
	} spio_state_t;

	// Edge hit for one sampled pin under a chosen edge mode
	function automatic logic spio_edge_hit(input logic prev, input logic cur, input spio_edge_t mode);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = prev & ~cur;
		unique case (mode)
			SPIO_EDGE_OFF:  spio_edge_hit = 1'b0;
			SPIO_EDGE_RISE: spio_edge_hit = rise;
			SPIO_EDGE_FALL: spio_edge_hit = fall;
			SPIO_EDGE_BOTH: spio_edge_hit = rise | fall;
		endcase
	endfunction

endpackage

// [core/spio_port.sv]
// Shared pin port: two 3-bit ports (A0..A2, B1..B3) with per-pin function sharing.
// Assumes an APB master on clk_i, pins sampled asynchronously, timers on clk_i.
// Pin index order: 0=A0 1=A1 2=A2 3=B1 4=B2 5=B3.
// Overview of operation
// - Six pins driven individually from output data register bits.
// - Each pin configurable: pull-up, open-drain, key; analog on all but B1; interrupt on A0..A2; timer output on all but A1.
// - Reset leaves pins as inputs without pull-up; STOP holds pin state.
// - Port B bit 1 never drives high; output mode is open-drain only.
// - Port B bits 2 and 3 offer selectable pull-down.
// - External interrupts detect rising, falling or both edges.
// - External interrupt pins also feed both timers as capture triggers.
// - Event-count pins feed both timers as external count sources.
// - Key-scan pins raise key interrupt and wake from STOP on chosen edge.
// - Analog input mode forces the pin pull-up off.
// - Wide timer 0 PWM goes to port A bit 2 or port B bit 1.
// - Narrow timer 1 PWM goes to port B bit 2.
// - Timer logic outputs go to port A bit 0 and port B bit 3.
// - Port B bit 1 becomes active-low reset input only when enabled.
// - Programming mode: clock in on A2, bidirectional data on A0.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "spio_map.svh"

module spio_port (
	input  wire logic                   clk_i,          // System clock, 10 MHz
	input  wire logic                   rst_n_i,        // Synchronous reset, active low
	input  wire logic                   ce_i,           // Clock enable, freezes all state
	input  wire spio_pkg::spio_apb_req_t apb_i,          // APB request
	output spio_pkg::spio_apb_rsp_t      apb_o,          // APB answer
	input  wire logic [5:0]             pin_i,          // Pin levels from pads
	output logic [5:0]                  pin_out_o,      // Pad output value
	output logic [5:0]                  pin_oe_o,       // Pad output enable, high drives
	output logic [5:0]                  pin_pu_o,       // Pull-up enable
	output logic [5:0]                  pin_pd_o,       // Pull-down enable
	output logic [5:0]                  pin_ana_o,      // Analog input mode
	input  wire logic                   stop_i,         // Device in STOP mode
	input  wire logic                   cfg_xrst_i,     // Code option for reset pin
	input  wire logic                   tmr0_pwm_i,     // Wide PWM from timer 0
	input  wire logic                   tmr1_pwm_i,     // Narrow PWM from timer 1
	input  wire logic                   tmr0_logic_i,   // Timer 0 logic output
	input  wire logic                   tmr1_logic_i,   // Timer 1 logic output
	input  wire logic                   prog_mode_i,    // Programming mode active
	input  wire logic                   prog_sda_out_i, // Programming data to drive
	input  wire logic                   prog_sda_oe_i,  // Programming data drive enable
	output logic                        irq_o,          // Combined interrupt, level
	output logic                        wake_o,         // STOP release pulse
	output logic                        ext_reset_n_o,  // External reset, active low
	output logic [1:0]                  cap_trig_o,     // Capture triggers to timers
	output logic [1:0]                  evt_cnt_o,      // Event count inputs to timers
	output logic                        prog_sck_o,     // Programming clock
	output logic                        prog_sda_in_o   // Programming data sampled
);

	spio_pkg::spio_state_t s_reg;
	spio_pkg::spio_state_t s_next;

	logic [5:0]  edge_any;
	logic        irq0_cur;
	logic        irq0_prev;
	logic [2:0]  ev;
	logic [31:0] rd_val;
	logic        rd_err;
	logic [5:0]  src;
	logic [5:0]  oe;
	logic [5:0]  odm;
	logic        xrst_en;

	// Edge detection works on synchronised levels only
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			edge_any[i] = spio_pkg::spio_edge_hit(s_reg.prev[i], s_reg.sync2[i],
				spio_pkg::spio_edge_t'(s_reg.func[`SPIO_FN_EK_LO +: 2]));
		end
		irq0_cur  = s_reg.func[`SPIO_FN_I0SEL] ? s_reg.sync2[`SPIO_PIN_A2] : s_reg.sync2[`SPIO_PIN_A0];
		irq0_prev = s_reg.func[`SPIO_FN_I0SEL] ? s_reg.prev[`SPIO_PIN_A2] : s_reg.prev[`SPIO_PIN_A0];
		ev[`SPIO_IRQ_E0] = spio_pkg::spio_edge_hit(irq0_prev, irq0_cur,
			spio_pkg::spio_edge_t'(s_reg.func[`SPIO_FN_E0_LO +: 2]));
		ev[`SPIO_IRQ_E1] = spio_pkg::spio_edge_hit(s_reg.prev[`SPIO_PIN_A1], s_reg.sync2[`SPIO_PIN_A1],
			spio_pkg::spio_edge_t'(s_reg.func[`SPIO_FN_E1_LO +: 2]));
		ev[`SPIO_IRQ_KEY] = |(edge_any & s_reg.key_en);
	end

	// Read decode; unmapped addresses answer with an error
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (apb_i.paddr)
			`SPIO_OFF_DATA:  rd_val[5:0]  = s_reg.data;
			`SPIO_OFF_DIR:   rd_val[5:0]  = s_reg.dir;
			`SPIO_OFF_PU:    rd_val[5:0]  = s_reg.pu;
			`SPIO_OFF_OD:    rd_val[5:0]  = s_reg.od;
			`SPIO_OFF_PD:    rd_val[5:0]  = s_reg.pd;
			`SPIO_OFF_ANA:   rd_val[5:0]  = s_reg.ana;
			`SPIO_OFF_KEY:   rd_val[5:0]  = s_reg.key_en;
			`SPIO_OFF_FUNC:  rd_val[12:0] = s_reg.func;
			`SPIO_OFF_PIN:   rd_val[5:0]  = s_reg.sync2;
			`SPIO_OFF_ISTS:  rd_val[2:0]  = s_reg.ists;
			`SPIO_OFF_IMASK: rd_val[2:0]  = s_reg.imask;
			default:         rd_err       = 1'b1;
		endcase
	end

	// Pad drive: data register, then alternate functions on top
	always_comb begin
		src = s_reg.data;
		oe  = s_reg.dir & ~s_reg.ana;
		if (s_reg.func[`SPIO_FN_TMA]) begin
			src[`SPIO_PIN_A0] = tmr0_logic_i;
			oe[`SPIO_PIN_A0]  = 1'b1;
		end
		if (s_reg.func[`SPIO_FN_TMB]) begin
			src[`SPIO_PIN_B3] = tmr1_logic_i;
			oe[`SPIO_PIN_B3]  = 1'b1;
		end
		if (s_reg.func[`SPIO_FN_WPWM] && !s_reg.func[`SPIO_FN_WPSEL]) begin
			src[`SPIO_PIN_A2] = tmr0_pwm_i;
			oe[`SPIO_PIN_A2]  = 1'b1;
		end
		if (s_reg.func[`SPIO_FN_WPWM] && s_reg.func[`SPIO_FN_WPSEL]) begin
			src[`SPIO_PIN_B1] = tmr0_pwm_i;
			oe[`SPIO_PIN_B1]  = 1'b1;
		end
		if (s_reg.func[`SPIO_FN_NPWM]) begin
			src[`SPIO_PIN_B2] = tmr1_pwm_i;
			oe[`SPIO_PIN_B2]  = 1'b1;
		end
		// Open-drain pins only pull low; B1 is always open-drain
		odm = s_reg.od | `SPIO_OD_FORCE;
		oe  = oe & ~(odm & src);
		src = src & ~odm;
		xrst_en = cfg_xrst_i | s_reg.func[`SPIO_FN_XRST];
		if (xrst_en) begin
			oe[`SPIO_PIN_B1] = 1'b0;
		end
		// Programming mode takes the drive of all six pads away from the CPU; only A0 may drive
		if (prog_mode_i) begin
			oe = 6'h00;
			oe[`SPIO_PIN_A0]  = prog_sda_oe_i;
			src[`SPIO_PIN_A0] = prog_sda_out_i;
		end
	end

	// Next-state logic for the whole block
	always_comb begin
		s_next = s_reg;
		s_next.sync1 = pin_i;
		s_next.sync2 = s_reg.sync1;
		s_next.prev  = s_reg.sync2;
		s_next.ists  = s_reg.ists;
		// APB: one wait state so the answer comes from a flop
		if (apb_i.psel && apb_i.penable && !s_reg.apb.pready) begin
			s_next.apb.pready  = 1'b1;
			s_next.apb.pslverr = rd_err;
			s_next.apb.prdata  = apb_i.pwrite ? 32'h0000_0000 : rd_val;
		end else if (s_reg.apb.pready) begin
			s_next.apb.pready  = 1'b0;
			s_next.apb.pslverr = 1'b0;
			s_next.apb.prdata  = 32'h0000_0000;
			if (apb_i.pwrite && !s_reg.apb.pslverr) begin
				unique case (apb_i.paddr)
					`SPIO_OFF_DATA:  s_next.data   = apb_i.pwdata[5:0];
					`SPIO_OFF_DIR:   s_next.dir    = apb_i.pwdata[5:0];
					`SPIO_OFF_PU:    s_next.pu     = apb_i.pwdata[5:0];
					`SPIO_OFF_OD:    s_next.od     = apb_i.pwdata[5:0];
					`SPIO_OFF_PD:    s_next.pd     = apb_i.pwdata[5:0] & `SPIO_PD_MASK;
					`SPIO_OFF_ANA:   s_next.ana    = apb_i.pwdata[5:0] & `SPIO_ANA_MASK;
					`SPIO_OFF_KEY:   s_next.key_en = apb_i.pwdata[5:0];
					`SPIO_OFF_FUNC:  s_next.func   = apb_i.pwdata[12:0];
					`SPIO_OFF_ISTS:  s_next.ists   = s_reg.ists & ~apb_i.pwdata[2:0];
					`SPIO_OFF_IMASK: s_next.imask  = apb_i.pwdata[2:0];
					default:         s_next.data   = s_reg.data;
				endcase
			end
		end
		// Set wins over a write-one clear in the same cycle
		s_next.ists = s_next.ists | ev;
		s_next.irq  = |(s_next.ists & s_next.imask);
		s_next.wake = ev[`SPIO_IRQ_KEY];
		// Pads frozen during STOP so levels survive entry
		if (!stop_i) begin
			s_next.pout = src;
			s_next.poe  = oe;
			s_next.ppu  = s_reg.pu & ~s_reg.ana;
			s_next.ppd  = s_reg.pd & `SPIO_PD_MASK;
			s_next.pana = s_reg.ana;
		end
		s_next.xrst_n = ~xrst_en | s_reg.sync2[`SPIO_PIN_B1];
		s_next.cap    = {s_reg.sync2[`SPIO_PIN_A1], irq0_cur};
		s_next.evt    = {s_reg.sync2[`SPIO_PIN_A1], irq0_cur};
		s_next.sck    = s_reg.sync2[`SPIO_PIN_A2];
		s_next.sda_in = s_reg.sync2[`SPIO_PIN_A0];
	end

	// State register; reset leaves every pin an input without pull-up
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_reg        <= '0;
			s_reg.xrst_n <= 1'b1;
			s_reg.func   <= `SPIO_RST_FUNC;
			s_reg.ists   <= `SPIO_RST_IRQ;
			s_reg.imask  <= `SPIO_RST_IRQ;
			s_reg.dir    <= `SPIO_RST_PINCFG;
			s_reg.pu     <= `SPIO_RST_PINCFG;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state flops
	assign apb_o         = s_reg.apb;
	assign pin_out_o     = s_reg.pout;
	assign pin_oe_o      = s_reg.poe;
	assign pin_pu_o      = s_reg.ppu;
	assign pin_pd_o      = s_reg.ppd;
	assign pin_ana_o     = s_reg.pana;
	assign irq_o         = s_reg.irq;
	assign wake_o        = s_reg.wake;
	assign ext_reset_n_o = s_reg.xrst_n;
	assign cap_trig_o    = s_reg.cap;
	assign evt_cnt_o     = s_reg.evt;
	assign prog_sck_o    = s_reg.sck;
	assign prog_sda_in_o = s_reg.sda_in;

	// Checks on the driven pads and events
	AST_B1_NO_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_oe_o[`SPIO_PIN_B1] |-> !pin_out_o[`SPIO_PIN_B1]) else $error("B1 driven high");
	AST_ANA_NO_PU: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pin_ana_o & pin_pu_o) == 6'h00) else $error("Pull-up on analog pin");
	AST_PD_B_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_pd_o[3:0] == 4'h0) else $error("Pull-down outside B2 B3");
	AST_RESET_INPUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> (pin_oe_o == 6'h00) && (pin_pu_o == 6'h00)) else $error("Pins not inputs after reset");
	AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		stop_i |=> $stable(pin_oe_o) && $stable(pin_out_o)) else $error("Pads moved in STOP");
	AST_IRQ0_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && ev[`SPIO_IRQ_E0] |=> s_reg.ists[`SPIO_IRQ_E0]) else $error("Edge lost on irq zero");
	AST_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i |=> cap_trig_o[1] == $past(s_reg.sync2[`SPIO_PIN_A1])) else $error("Capture route wrong");
	AST_KEY_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && ev[`SPIO_IRQ_KEY] |=> wake_o && s_reg.ists[`SPIO_IRQ_KEY]) else $error("Key edge missed");
	AST_WPWM_A2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !stop_i && !prog_mode_i && s_reg.func[`SPIO_FN_WPWM] && !s_reg.func[`SPIO_FN_WPSEL]
		&& !s_reg.od[`SPIO_PIN_A2] |=> pin_out_o[`SPIO_PIN_A2] == $past(tmr0_pwm_i)) else $error("PWM on A2 wrong");
	AST_XRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && cfg_xrst_i |=> ext_reset_n_o == $past(s_reg.sync2[`SPIO_PIN_B1])) else $error("Reset pin wrong");
	AST_PROG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !stop_i && prog_mode_i |=> !pin_oe_o[`SPIO_PIN_A2]
		&& pin_out_o[`SPIO_PIN_A0] == $past(prog_sda_out_i)) else $error("Programming pins wrong");
	AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		irq_o == |(s_reg.ists & s_reg.imask)) else $error("Interrupt level wrong");

endmodule

// [dv/spio_pads.sv]
// Pad wiring model: design drive, bench drivers, pulls, floating lines.
// Assumes one clock; a line nobody holds flips every cycle.
`timescale 1ns/1ps

module spio_pads (
	input  wire logic       clk_i,     // System clock
	input  wire logic [5:0] out_i,     // Design drive value
	input  wire logic [5:0] oe_i,      // Design drive enable
	input  wire logic [5:0] pu_i,      // Pull-up on
	input  wire logic [5:0] pd_i,      // Pull-down on
	input  wire logic [5:0] ext_val_i, // Outside circuit value
	input  wire logic [5:0] ext_en_i,  // Outside circuit drives
	output logic [5:0]      pin_o      // Resolved line level
);
	logic [5:0] last_q = 6'h00;

	// Design drive wins, then outside, then pulls, else a changing level
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (oe_i[i])
				pin_o[i] = out_i[i];
			else if (ext_en_i[i])
				pin_o[i] = ext_val_i[i];
			else if (pu_i[i] || pd_i[i])
				pin_o[i] = pu_i[i];
			else
				pin_o[i] = ~last_q[i];
		end
	end

	// Floating lines never settle, so stale values cannot pass for data
	always_ff @(posedge clk_i) begin
		last_q <= pin_o;
	end
endmodule

// [dv/spio_port_tb.sv]
// Self-checking bench of the shared pin port with APB master tasks.
// Assumes spio_pads for the outside circuits; outside levels hold 5 cycles.
`timescale 1ns/1ps
`include "spio_map.svh"

module spio_port_tb;
	logic clk_i = 0, rst_n_i = 0, stp = 0, xr = 0, pm = 0, so = 0, soe = 0, woke = 0, er;
	logic [3:0] tm = 0;
	logic [5:0] ev = 0, ee = 6'h3F, po, poe, ppu, ppd, pan, pin;
	logic irq, wk, xrn, sck, sdi;
	logic [1:0] cap, evt;
	logic [31:0] rd;
	spio_pkg::spio_apb_req_t req = '0;
	spio_pkg::spio_apb_rsp_t rsp;
	int n_errors = 0, num_checks = 0, cnt = 0;

	always #50 clk_i = ~clk_i;

	spio_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .apb_i(req), .apb_o(rsp),
		.pin_i(pin), .pin_out_o(po), .pin_oe_o(poe), .pin_pu_o(ppu), .pin_pd_o(ppd),
		.pin_ana_o(pan), .stop_i(stp), .cfg_xrst_i(xr), .tmr0_pwm_i(tm[0]), .tmr1_pwm_i(tm[1]),
		.tmr0_logic_i(tm[2]), .tmr1_logic_i(tm[3]), .prog_mode_i(pm), .prog_sda_out_i(so),
		.prog_sda_oe_i(soe), .irq_o(irq), .wake_o(wk), .ext_reset_n_o(xrn), .cap_trig_o(cap),
		.evt_cnt_o(evt), .prog_sck_o(sck), .prog_sda_in_o(sdi));

	spio_pads i_pads (.clk_i(clk_i), .out_i(po), .oe_i(poe), .pu_i(ppu), .pd_i(ppd),
		.ext_val_i(ev), .ext_en_i(ee), .pin_o(pin));

	// Wake is a one-cycle pulse, so it is caught here
	always @(posedge clk_i) begin
		if (wk === 1'b1)
			woke <= 1'b1;
		cnt <= cnt + 1;
		if (cnt == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task conclude;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task rst;
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		cyc(4);
		rst_n_i <= 1'b1;
	endtask

	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		if (k >= 50)
			n_errors++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask

	task sc_pull;
		rst();
		chk("oe", 6'h00, poe);
		chk("pu", 6'h00, ppu);
		chk("xrst", 1'b1, xrn);
		rdc("dir", `SPIO_OFF_DIR, 32'h0000_0000);
		wr(`SPIO_OFF_PU, 32'h0000_003F);
		wr(`SPIO_OFF_PD, 32'h0000_003F);
		cyc(2);
		chk("pu", 6'h3F, ppu);
		chk("pd", 6'h30, ppd);
		rdc("pdreg", `SPIO_OFF_PD, 32'h0000_0030);
		wr(`SPIO_OFF_ANA, 32'h0000_003F);
		cyc(2);
		chk("pu", 6'h08, ppu);
		chk("ana", 6'h37, pan);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("slverr", 1'b1, er);
	endtask

	// Rise, fall and both edge modes on the zero interrupt, key scan on both edges
	task sc_irq;
		for (int m = 1; m < 4; m++) begin
			ev <= 6'h00;
			rst();
			wr(`SPIO_OFF_IMASK, 32'h0000_0001);
			wr(`SPIO_OFF_KEY, 32'h0000_0001);
			wr(`SPIO_OFF_FUNC, (m << 6) | (3 << 10));
			woke <= 1'b0;
			ev <= 6'h01;
			cyc(5);
			rdc("ists", `SPIO_OFF_ISTS, 4 | (m != 2));
			chk("irq", m != 2, irq);
			chk("wake", 1'b1, woke);
			chk("cap", 2'h1, cap);
			chk("evt", 2'h1, evt);
			wr(`SPIO_OFF_ISTS, 32'h0000_0007);
			rdc("ists", `SPIO_OFF_ISTS, 32'h0000_0000);
			ev <= 6'h00;
			cyc(5);
			rdc("ists", `SPIO_OFF_ISTS, 4 | (m != 1));
			chk("irq", m != 1, irq);
			wr(`SPIO_OFF_IMASK, 32'h0000_0000);
			cyc(2);
			chk("irq", 1'b0, irq);
		end
		// Irq one on A1, irq zero moved to A2
		ev <= 6'h00;
		rst();
		wr(`SPIO_OFF_FUNC, (1 << 6) | (1 << 8) | (1 << 12));
		wr(`SPIO_OFF_IMASK, 32'h0000_0003);
		ev <= 6'h06;
		cyc(5);
		rdc("ists", `SPIO_OFF_ISTS, 32'h0000_0003);
		chk("irq", 1'b1, irq);
		chk("cap", 2'h3, cap);
		chk("evt", 2'h3, evt);
		ev <= 6'h00;
	endtask

	task sc_out;
		rst();
		wr(`SPIO_OFF_DATA, 32'h0000_003F);
		wr(`SPIO_OFF_DIR, 32'h0000_003F);
		cyc(2);
		chk("out", 6'h37, po);
		chk("oe", 6'h37, poe);
		stp <= 1'b1;
		wr(`SPIO_OFF_DATA, 32'h0000_0000);
		cyc(3);
		chk("out", 6'h37, po);
		stp <= 1'b0;
		cyc(3);
		chk("out", 6'h00, po);
		chk("oe", 6'h3F, poe);
		wr(`SPIO_OFF_OD, 32'h0000_0001);
		wr(`SPIO_OFF_DATA, 32'h0000_003F);
		cyc(2);
		chk("oe", 6'h36, poe);
		chk("out", 6'h36, po);
	endtask

	task sc_alt;
		rst();
		tm <= 4'hF;
		wr(`SPIO_OFF_FUNC, 32'h0000_0017);
		cyc(3);
		chk("out", 6'h35, po);
		chk("oe", 6'h35, poe);
		tm <= 4'h0;
		wr(`SPIO_OFF_FUNC, 32'h0000_001F);
		cyc(3);
		chk("out", 6'h00, po);
		chk("oe", 6'h39, poe);
	endtask

	// Code option first, then register option
	task sc_xrst;
		rst();
		for (int k = 0; k < 2; k++) begin
			xr <= (k == 0);
			wr(`SPIO_OFF_FUNC, k << 5);
			ev <= 6'h37;
			cyc(5);
			chk("xrst", 1'b0, xrn);
			ev <= 6'h3F;
			cyc(5);
			chk("xrst", 1'b1, xrn);
		end
		wr(`SPIO_OFF_FUNC, 32'h0000_0000);
		ev <= 6'h37;
		cyc(5);
		chk("xrst", 1'b1, xrn);
	endtask

	task sc_prog;
		rst();
		pm <= 1'b1;
		ev <= 6'h04;
		so <= 1'b1;
		soe <= 1'b1;
		wr(`SPIO_OFF_DIR, 32'h0000_003F);
		cyc(5);
		chk("sck", 1'b1, sck);
		chk("oe", 6'h01, poe);
		chk("sda", 1'b1, po[0]);
		soe <= 1'b0;
		ev <= 6'h01;
		cyc(5);
		chk("sck", 1'b0, sck);
		chk("sdain", 1'b1, sdi);
		pm <= 1'b0;
	endtask

	initial begin
		sc_pull();
		sc_irq();
		sc_out();
		sc_alt();
		sc_xrst();
		sc_prog();
		conclude();
	end
endmodule
